/* File: list_ctrl_cfg.svh */
// Constants for the list control and command/status register bank.
// Assumes a 32-bit register port with byte offsets from the operational base.
`ifndef LIST_CTRL_CFG_SVH
`define LIST_CTRL_CFG_SVH

`define OFS_LIST_CONTROL     8'h04
`define OFS_COMMAND_STATUS   8'h08

`define CTL_RATIO_LSB        0
`define CTL_PERIODIC_BIT     2
`define CTL_ISO_BIT          3
`define CTL_CONTROL_BIT      4
`define CTL_BULK_BIT         5
`define CTL_RESET_VALUE      32'h00000000

`define CMD_RESET_BIT        0
`define CMD_CFILL_BIT        1
`define CMD_BFILL_BIT        2
`define CMD_OWN_BIT          3
`define CMD_OVR_LSB          16
`define CMD_RESET_VALUE      32'h00000000

`define SOFT_RESET_NS        40
`define CLK_PERIOD_NS        4
`define SOFT_RESET_CYCLES    ((`SOFT_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: list_ctrl_pkg.sv */
// Types for the list control and command/status register bank.
// Assumes list_ctrl_cfg.svh supplies the numeric constants.
package list_ctrl_pkg;
    typedef logic [31:0] word_t;
    typedef logic [7:0]  offset_t;
    typedef logic [1:0]  ratio_t;
    typedef enum logic [3:0] {
        SEL_IDLE     = 4'b0001,
        SEL_CONTROL  = 4'b0010,
        SEL_BULK     = 4'b0100,
        SEL_DONE     = 4'b1000
    } select_t;
endpackage

/* File: ratio_arbiter.sv */
// Control-versus-bulk service arbiter for the non-periodic lists.
// Assumes the list engine pulses descriptor events one per cycle.
`timescale 1ns/100ps
module ratio_arbiter
    import list_ctrl_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   nrst,
    input  wire list_ctrl_pkg::ratio_t  ratio,
    input  wire logic                   controlDone,
    input  wire logic                   bulkDone,
    output logic                        preferControl
);
    import list_ctrl_pkg::*;

    logic [2:0] served_reg;
    logic [2:0] served_next;
    logic [2:0] limit;

    // Ratio compare before each non-periodic pick
    assign limit         = {1'b0, ratio} + 3'h1;
    assign preferControl = served_reg < limit;
    // Count kept across frames, cleared only by bulk service or nrst
    assign served_next = bulkDone ? 3'h0 :
                         (controlDone && preferControl) ? served_reg + 3'h1 : served_reg;

    always_ff @(posedge clk)
    begin
        if (!nrst)
            served_reg <= 3'h0;
        else
            served_reg <= served_next;
    end
endmodule // ratio_arbiter

/* File: list_control.sv */
// Control register enables and write-to-set command/status register.
// Assumes a simple synchronous register port and a list engine outside.
// How it works
// - Control list runs from the frame after enable; stops at once when cleared.
// - Engine samples control enable each time it would walk that list.
// - Isochronous descriptor with iso disabled halts periodic list, go non-periodic.
// - Isochronous enable changes apply only from the next frame.
// - Periodic enable latched per frame and checked before the periodic list.
// - Ratio field 00b..11b selects 1:1 to 4:1 control to bulk.
// - Ratio compared with count of nonempty control descriptors served.
// - Control service count survives frame boundaries.
// - Command/status writes set ones and leave zero bits unchanged.
// - Command/status reads return every bit as it stands.
// - Periodic list unfinished at end of frame counts as overrun.
// - Each overrun increments the counter and pulses the overrun flag.
// - Count 17:16, ownership 3, bulk-filled 2, control-filled 1, reset 0.
// - Overrun count starts at 00b, wraps at 11b, counts every overrun.
// - Ownership request raises ownership flag; clears after changeover.
// - Bulk-filled zero skips bulk; reaching the head clears it, refound descriptor sets it.
`timescale 1ns/100ps
`include "list_ctrl_cfg.svh"
module list_control
(
    input  wire logic                    clk,
    input  wire logic                    nrst,
    input  wire list_ctrl_pkg::offset_t  regAddr,
    input  wire logic                    regWrite,
    input  wire logic                    regRead,
    input  wire list_ctrl_pkg::word_t    regWdata,
    output list_ctrl_pkg::word_t         regRdata,
    input  wire logic                    frameStart,
    input  wire logic                    frameEnd,
    input  wire logic                    periodicBusy,
    input  wire logic                    isoFound,
    input  wire logic                    controlHead,
    input  wire logic                    bulkHead,
    input  wire logic                    controlTdFound,
    input  wire logic                    bulkTdFound,
    input  wire logic                    controlDone,
    input  wire logic                    bulkDone,
    input  wire logic                    changeoverDone,
    output logic                         runPeriodic,
    output logic                         runIso,
    output logic                         runControl,
    output logic                         runBulk,
    output logic                         isoHalt,
    output logic                         preferControl,
    output logic                         overrunFlagSet,
    output logic                         ownershipFlagSet,
    output logic                         softResetActive
);
    import list_ctrl_pkg::*;

    word_t        control_reg;
    logic         periodicFrame_reg;
    logic         isoFrame_reg;
    logic         controlFrame_reg;
    logic         bulkFrame_reg;
    logic [1:0]   overrunCount_reg;
    logic         ownReq_reg;
    logic         bulkFill_reg;
    logic         ctrlFill_reg;
    logic         softReset_reg;
    logic [7:0]   resetTimer_reg;
    logic         overrunPulse_reg;
    logic         ownPulse_reg;
    word_t        rdata_reg;

    logic         wrControl;
    logic         wrCommand;
    logic         overrunEvent;
    logic         resetDone;
    logic [1:0]   overrunCount_next;
    logic         bulkFill_next;
    logic         ctrlFill_next;
    logic         ownReq_next;
    logic         softReset_next;
    word_t        commandView;
    word_t        rdata_next;

    assign wrControl = regWrite && (regAddr == `OFS_LIST_CONTROL);
    assign wrCommand = regWrite && (regAddr == `OFS_COMMAND_STATUS);

    // Frame-latched enables; mid-frame enable sets wait for the next SOF
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            periodicFrame_reg <= 1'b0;
            isoFrame_reg      <= 1'b0;
            controlFrame_reg  <= 1'b0;
            bulkFrame_reg     <= 1'b0;
        end
        else if (frameStart)
        begin
            periodicFrame_reg <= control_reg[`CTL_PERIODIC_BIT];
            isoFrame_reg      <= control_reg[`CTL_ISO_BIT];
            controlFrame_reg  <= control_reg[`CTL_CONTROL_BIT];
            bulkFrame_reg     <= control_reg[`CTL_BULK_BIT];
        end
        else if (wrControl)
        begin
            // A clear drops the frame enable so a re-set waits for the next SOF
            periodicFrame_reg <= periodicFrame_reg && regWdata[`CTL_PERIODIC_BIT];
            controlFrame_reg  <= controlFrame_reg && regWdata[`CTL_CONTROL_BIT];
            bulkFrame_reg     <= bulkFrame_reg && regWdata[`CTL_BULK_BIT];
        end
    end

    // Live enable also gates the periodic, control and bulk walks so a clear stops them at once
    assign runControl  = controlFrame_reg && control_reg[`CTL_CONTROL_BIT]
                         && controlHead && ctrlFill_reg;
    assign runBulk     = bulkFrame_reg && control_reg[`CTL_BULK_BIT]
                         && bulkHead && bulkFill_reg;
    assign runPeriodic = periodicFrame_reg && control_reg[`CTL_PERIODIC_BIT];
    assign runIso      = isoFrame_reg;
    assign isoHalt     = isoFound && !isoFrame_reg;

    ratio_arbiter u_ratio (
        .clk           (clk),
        .nrst          (nrst),
        .ratio         (control_reg[`CTL_RATIO_LSB +: 2]),
        .controlDone   (controlDone),
        .bulkDone      (bulkDone),
        .preferControl (preferControl)
    );

    always_ff @(posedge clk)
    begin
        if (!nrst)
            control_reg <= `CTL_RESET_VALUE;
        else if (wrControl)
            control_reg <= {26'h0, regWdata[5:0]};
    end

    assign overrunEvent      = frameEnd && periodicBusy;
    assign overrunCount_next = overrunEvent ? overrunCount_reg + 2'h1
                                            : overrunCount_reg;
    // Hardware sets win over same-cycle clears
    assign ctrlFill_next = (wrCommand && regWdata[`CMD_CFILL_BIT]) || controlTdFound
                           || (ctrlFill_reg && !(controlHead && runControl));
    assign bulkFill_next = (wrCommand && regWdata[`CMD_BFILL_BIT]) || bulkTdFound
                           || (bulkFill_reg && !(bulkHead && runBulk));
    assign ownReq_next   = (wrCommand && regWdata[`CMD_OWN_BIT])
                           || (ownReq_reg && !changeoverDone);
    assign resetDone     = softReset_reg && (resetTimer_reg == 8'h00);
    assign softReset_next = (wrCommand && regWdata[`CMD_RESET_BIT])
                           || (softReset_reg && !resetDone);

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            overrunCount_reg <= 2'h0;
            ctrlFill_reg     <= 1'b0;
            bulkFill_reg     <= 1'b0;
            ownReq_reg       <= 1'b0;
            softReset_reg    <= 1'b0;
            overrunPulse_reg <= 1'b0;
            ownPulse_reg     <= 1'b0;
        end
        else
        begin
            overrunCount_reg <= overrunCount_next;
            ctrlFill_reg     <= ctrlFill_next;
            bulkFill_reg     <= bulkFill_next;
            ownReq_reg       <= ownReq_next;
            softReset_reg    <= softReset_next;
            overrunPulse_reg <= overrunEvent;
            ownPulse_reg     <= wrCommand && regWdata[`CMD_OWN_BIT];
        end
    end

    // Soft reset length counter
    always_ff @(posedge clk)
    begin
        if (!nrst)
            resetTimer_reg <= 8'h00;
        else if (wrCommand && regWdata[`CMD_RESET_BIT] && !softReset_reg)
            resetTimer_reg <= 8'(`SOFT_RESET_CYCLES - 1);
        else if (resetTimer_reg != 8'h00)
            resetTimer_reg <= resetTimer_reg - 8'h01;
    end

    assign commandView = {14'h0, overrunCount_reg, 12'h0,
                          ownReq_reg, bulkFill_reg, ctrlFill_reg, softReset_reg};
    assign rdata_next  = !regRead ? rdata_reg :
                         (regAddr == `OFS_LIST_CONTROL)   ? control_reg :
                         (regAddr == `OFS_COMMAND_STATUS) ? commandView : 32'h00000000;

    always_ff @(posedge clk)
    begin
        if (!nrst)
            rdata_reg <= 32'h00000000;
        else
            rdata_reg <= rdata_next;
    end

    assign regRdata         = rdata_reg;
    assign overrunFlagSet   = overrunPulse_reg;
    assign ownershipFlagSet = ownPulse_reg;
    assign softResetActive  = softReset_reg;
endmodule // list_control

/* File: list_control_monitor.sv */
// Checker for the list control register bank ports.
// Assumes it is bound to list_control; one clock, sync active-low reset.
`timescale 1ns/100ps
module list_control_monitor
    import list_ctrl_pkg::*;
(
    input wire logic clk, nrst, regWrite, regRead, frameStart, frameEnd, periodicBusy,
    input wire logic isoFound, bulkDone, runControl, runIso, runPeriodic, isoHalt,
    input wire logic preferControl, overrunFlagSet, ownershipFlagSet, softResetActive,
    input wire list_ctrl_pkg::offset_t regAddr,
    input wire list_ctrl_pkg::word_t   regWdata,
    input wire list_ctrl_pkg::word_t   regRdata
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    wire cmdWr = regWrite && regAddr == 8'h08;
    wire ctlWr = regWrite && regAddr == 8'h04;
    logic ctlLive_reg;
    logic ctlFrame_reg;
    logic isoLive_reg;
    logic isoFrame_reg;
    // Reference copy of the live and frame-latched enables
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            ctlLive_reg  <= 1'b0;
            ctlFrame_reg <= 1'b0;
            isoLive_reg  <= 1'b0;
            isoFrame_reg <= 1'b0;
        end
        else
        begin
            if (ctlWr)
            begin
                ctlLive_reg <= regWdata[4];
                isoLive_reg <= regWdata[3];
            end
            if (frameStart)
            begin
                ctlFrame_reg <= ctlLive_reg;
                isoFrame_reg <= isoLive_reg;
            end
            else if (ctlWr && !regWdata[4])
                ctlFrame_reg <= 1'b0;
        end
    end
    AST_OVR_SET: assert property (frameEnd && periodicBusy |=> overrunFlagSet)
        else $error("overrun flag missing");
    AST_OVR_NONE: assert property (!(frameEnd && periodicBusy) |=> !overrunFlagSet)
        else $error("overrun flag without overrun");
    AST_SOFT_GO: assert property (cmdWr && regWdata[0] |=> softResetActive)
        else $error("soft reset not started");
    AST_SOFT_LEN: assert property ($rose(softResetActive) |-> softResetActive[*8] ##1
        softResetActive[*2] ##1 !softResetActive) else $error("soft reset length wrong");
    AST_CTL_OFF: assert property (ctlWr && !regWdata[4] |=> !runControl)
        else $error("control list still running");
    AST_RUN_SOF: assert property ($rose(runPeriodic) |-> $past(frameStart))
        else $error("list started outside frame start");
    AST_CTL_FRAME: assert property (runControl |-> ctlFrame_reg && ctlLive_reg)
        else $error("control list run without frame enable");
    AST_ISO_SOF: assert property ($rose(runIso) |-> $past(frameStart))
        else $error("iso enable applied mid frame");
    AST_ISO_HALT: assert property (isoHalt == (isoFound && !isoFrame_reg))
        else $error("iso halt without iso descriptor");
    AST_PREF: assert property (bulkDone |=> preferControl)
        else $error("control not preferred after bulk");
    AST_RDATA: assert property (!$past(regRead) |-> $stable(regRdata))
        else $error("read data changed without read");
    AST_OWN: assert property (cmdWr && regWdata[3] |-> ##[1:2] ownershipFlagSet)
        else $error("ownership flag missing");
endmodule // list_control_monitor

/* File: tb_list_control.sv */
// Self-checking bench for list_control with an integer reference model.
// Assumes list_control_monitor is compiled alongside.
`timescale 1ns/100ps
module tb_list_control;
    import list_ctrl_pkg::*;
    logic clk = 0, nrst = 0, regWrite = 0, regRead = 0, frameStart = 0, frameEnd = 0;
    logic periodicBusy = 0, isoFound = 0, controlHead = 0, bulkHead = 0, controlTdFound = 0;
    logic bulkTdFound = 0, controlDone = 0, bulkDone = 0, changeoverDone = 0;
    logic runPeriodic, runIso, runControl, runBulk, isoHalt, preferControl;
    logic overrunFlagSet, ownershipFlagSet, softResetActive;
    offset_t regAddr = 8'h00;
    word_t   regWdata = 32'h00000000, regRdata, rd;
    integer  num_errors = 0, compares = 0, cnt, i, r;
    list_control dut_u (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .frameStart(frameStart),
        .frameEnd(frameEnd), .periodicBusy(periodicBusy), .isoFound(isoFound),
        .controlHead(controlHead), .bulkHead(bulkHead), .controlTdFound(controlTdFound),
        .bulkTdFound(bulkTdFound), .controlDone(controlDone), .bulkDone(bulkDone),
        .changeoverDone(changeoverDone), .runPeriodic(runPeriodic), .runIso(runIso),
        .runControl(runControl), .runBulk(runBulk), .isoHalt(isoHalt),
        .preferControl(preferControl), .overrunFlagSet(overrunFlagSet),
        .ownershipFlagSet(ownershipFlagSet), .softResetActive(softResetActive));
    initial forever #2 clk = ~clk;
    task automatic chk(input string nm, input word_t seen, input word_t exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results;
        if (num_errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(input offset_t a, input word_t d);
        @(posedge clk);
        regWrite <= 1'h1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'h0;
    endtask
    task automatic rdc(input offset_t a, input word_t exp, input string nm);
        @(posedge clk);
        regRead <= 1'h1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'h0;
        #1 chk(nm, regRdata, exp);
    endtask
    task automatic drive(input string nm, input logic v);
        case (nm)
            "bulkDone":       bulkDone <= v;
            "controlDone":    controlDone <= v;
            "frameStart":     frameStart <= v;
            "frameEnd":       frameEnd <= v;
            "controlHead":    controlHead <= v;
            "controlTdFound": controlTdFound <= v;
            "bulkTdFound":    bulkTdFound <= v;
            "changeoverDone": changeoverDone <= v;
            default:          num_errors++;
        endcase
    endtask
    task automatic pulse(input string nm);
        @(posedge clk);
        drive(nm, 1'h1);
        @(posedge clk);
        drive(nm, 1'h0);
        #1;
    endtask
    initial
    begin
        void'($urandom(7860));
        repeat (20) @(posedge clk);
        nrst <= 1'h1;
        rdc(8'h04, 32'h0, "ctl reset");
        rdc(8'h08, 32'h0, "cmd reset");
        rdc(8'h10, 32'h0, "unmapped");
        rd = $urandom();
        wr(8'h04, rd);
        rdc(8'h04, rd & 32'h3F, "ctl rw");
        for (r = 0; r < 4; r++)
        begin
            wr(8'h04, r); // Driver sets the ratio to r
            pulse("bulkDone");
            cnt = 0;
            for (i = 0; i < 6; i++)
            begin
                chk("prefer", preferControl, cnt <= r);
                pulse("controlDone");
                if (cnt <= r)
                    cnt++;
                pulse("frameStart");
            end
        end
        wr(8'h08, 32'h2); // Reserved bits written as zero
        controlHead <= 1'h1;
        wr(8'h04, 32'h1C);
        #1 chk("ctl early", runControl, 0);
        pulse("frameStart");
        chk("run ctl", runControl, 1);
        chk("run per", runPeriodic, 1);
        chk("run iso", runIso, 1);
        @(posedge clk) controlHead <= 1'h0;
        @(posedge clk) isoFound <= 1'h1;
        wr(8'h04, 32'h14);
        #1 chk("iso same frame", isoHalt, 0);
        pulse("frameStart");
        chk("iso halt", isoHalt, 1);
        @(posedge clk) isoFound <= 1'h0;
        wr(8'h08, 32'h2);
        wr(8'h08, 32'h4);
        rdc(8'h08, 32'h6, "write set");
        pulse("controlHead");
        rdc(8'h08, 32'h4, "cfill clr");
        pulse("controlTdFound");
        rdc(8'h08, 32'h6, "cfill set");
        wr(8'h04, 32'h20); // List edits only while control is off
        #1 chk("ctl off", runControl, 0);
        pulse("frameStart");
        @(posedge clk) bulkHead <= 1'h1;
        #1 chk("run bulk", runBulk, 1);
        @(posedge clk);
        #1 chk("bulk skip", runBulk, 0);
        @(posedge clk) bulkHead <= 1'h0;
        rdc(8'h08, 32'h2, "bfill clr");
        pulse("bulkTdFound");
        @(posedge clk) periodicBusy <= 1'h1;
        for (i = 1; i < 6; i++)
        begin
            pulse("frameEnd");
            chk("ovr flag", overrunFlagSet, 1);
            rdc(8'h08, {14'h0000, i[1:0], 16'h0006}, "soc");
        end
        @(posedge clk) periodicBusy <= 1'h0;
        wr(8'h08, 32'h8);
        #1 chk("own flag", ownershipFlagSet, 1);
        rdc(8'h08, 32'h0001000E, "own req");
        pulse("changeoverDone");
        rdc(8'h08, 32'h00010006, "own clr");
        wr(8'h08, 32'h1);
        #1 chk("soft on", softResetActive, 1);
        repeat (10) @(posedge clk);
        #1 chk("soft done", softResetActive, 0);
        @(posedge clk) nrst <= 1'h0;
        repeat (3) @(posedge clk);
        nrst <= 1'h1;
        rdc(8'h08, 32'h0, "cmd rst");
        chk("prefer rst", preferControl, 1);
        results();
    end
endmodule // tb_list_control
bind list_control list_control_monitor mon_u (.clk(clk), .nrst(nrst), .regWrite(regWrite),
    .regRead(regRead), .frameStart(frameStart), .frameEnd(frameEnd),
    .periodicBusy(periodicBusy), .isoFound(isoFound), .bulkDone(bulkDone),
    .runControl(runControl), .runIso(runIso), .runPeriodic(runPeriodic), .isoHalt(isoHalt),
    .preferControl(preferControl), .overrunFlagSet(overrunFlagSet),
    .ownershipFlagSet(ownershipFlagSet), .softResetActive(softResetActive),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata));
